// ### jtdr_pkg.sv
// Constants, state codes and carrier types for the test-port data registers.
// Assumes one sampling clock well above the test clock rate.
package jtdr_pkg;

  // ------------------------------------------------------------
  // Widths
  // ------------------------------------------------------------
  localparam int IR_W = 3;
  localparam int ID_W = 32;
  localparam int BSR_W = 127;
  localparam int PAD_W = 126;

  // ------------------------------------------------------------
  // Instruction codes
  // ------------------------------------------------------------
  localparam logic [2:0] IR_EXTEST = 3'h0;
  localparam logic [2:0] IR_IDCODE = 3'h1;
  localparam logic [2:0] IR_SAMPZ = 3'h2;
  localparam logic [2:0] IR_SAMPLE = 3'h4;
  localparam logic [2:0] IR_BYPASS = 3'h7;
  localparam logic [2:0] IR_RST = IR_IDCODE;

  // ------------------------------------------------------------
  // Identification word layout and fixed values
  // ------------------------------------------------------------
  localparam int ID_PART_LSB = 12;
  localparam int ID_MAKER_LSB = 1;
  localparam int ID_START_POS = 0;
  localparam logic ID_START = 1'b1;
  // Arbitrary neutral values
  localparam logic [19:0] ID_PART_DEF = 20'h00A5C;
  localparam logic [10:0] ID_MAKER_DEF = 11'h2B4;

  // ------------------------------------------------------------
  // Capture and reset values
  // ------------------------------------------------------------
  localparam logic BYP_CAP = 1'b0;
  localparam logic INT_CELL_CAP = 1'b1;
  localparam int INT_CELL_POS = 126;
  localparam logic [BSR_W-1:0] BSR_RST = '0;

  // ------------------------------------------------------------
  // Test access controller states
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    TLR = 4'h0, RTI = 4'h1, SEL_DR = 4'h2, CAP_DR = 4'h3,
    SHF_DR = 4'h4, EX1_DR = 4'h5, PAU_DR = 4'h6, EX2_DR = 4'h7,
    UPD_DR = 4'h8, SEL_IR = 4'h9, CAP_IR = 4'hA, SHF_IR = 4'hB,
    EX1_IR = 4'hC, PAU_IR = 4'hD, EX2_IR = 4'hE, UPD_IR = 4'hF
  } jtdr_tap_t;

  // ------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } jtdr_pin_t;

  typedef struct packed {
    logic pad_sel;
    logic dq_hiz;
    logic odt_off;
  } jtdr_ctl_t;

endpackage

// ### jtdr_data_regs.sv
// Boundary-scan data registers with their test access controller.
// Assumes test pins arrive asynchronously and the test clock is slow
// against ref_clk_i, at least four sampling clocks per phase.
`timescale 1ns/1ps
module jtdr_data_regs #(
  parameter logic [19:0] PART_ID = jtdr_pkg::ID_PART_DEF,
  parameter logic [10:0] MAKER_ID = jtdr_pkg::ID_MAKER_DEF,
  parameter logic [125:0] NC_MASK = '0
) (
  input wire logic ref_clk_i,
  input wire logic srst_i,
  input wire jtdr_pkg::jtdr_pin_t pin_i,
  input wire logic [125:0] pad_level_i,
  output logic tdo_o,
  output logic tdo_oe_o,
  output logic [125:0] pad_drive_o,
  output jtdr_pkg::jtdr_ctl_t ctl_o
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    jtdr_pkg::jtdr_pin_t pin_m;
    jtdr_pkg::jtdr_pin_t pin_s;
    logic tck_d;
    logic [125:0] pad_m;
    logic [125:0] pad_s;
    jtdr_pkg::jtdr_tap_t tap;
    logic [2:0] ir_sh;
    logic [2:0] ir;
    logic byp;
    logic [31:0] id_sh;
    logic [126:0] bsr;
    logic [126:0] upd;
    logic tdo;
    logic tdo_oe;
  } jtdr_state_t;

  jtdr_state_t r;
  jtdr_state_t r_nxt;

  localparam logic [31:0] ID_WORD = {PART_ID, MAKER_ID, jtdr_pkg::ID_START};

  logic rise;
  logic fall;
  logic sel_bsr;
  logic sel_id;
  logic sel_byp;
  logic is_extest;
  logic is_sampz;

  // ------------------------------------------------------------
  // Controller next state
  // ------------------------------------------------------------
  function automatic jtdr_pkg::jtdr_tap_t tap_next(
    input jtdr_pkg::jtdr_tap_t s, input logic tms);
    jtdr_pkg::jtdr_tap_t n;
    n = s;
    case (s)
      jtdr_pkg::TLR: n = tms ? jtdr_pkg::TLR : jtdr_pkg::RTI;
      jtdr_pkg::RTI: n = tms ? jtdr_pkg::SEL_DR : jtdr_pkg::RTI;
      jtdr_pkg::SEL_DR: n = tms ? jtdr_pkg::SEL_IR : jtdr_pkg::CAP_DR;
      jtdr_pkg::CAP_DR: n = tms ? jtdr_pkg::EX1_DR : jtdr_pkg::SHF_DR;
      jtdr_pkg::SHF_DR: n = tms ? jtdr_pkg::EX1_DR : jtdr_pkg::SHF_DR;
      jtdr_pkg::EX1_DR: n = tms ? jtdr_pkg::UPD_DR : jtdr_pkg::PAU_DR;
      jtdr_pkg::PAU_DR: n = tms ? jtdr_pkg::EX2_DR : jtdr_pkg::PAU_DR;
      jtdr_pkg::EX2_DR: n = tms ? jtdr_pkg::UPD_DR : jtdr_pkg::SHF_DR;
      jtdr_pkg::UPD_DR: n = tms ? jtdr_pkg::SEL_DR : jtdr_pkg::RTI;
      jtdr_pkg::SEL_IR: n = tms ? jtdr_pkg::TLR : jtdr_pkg::CAP_IR;
      jtdr_pkg::CAP_IR: n = tms ? jtdr_pkg::EX1_IR : jtdr_pkg::SHF_IR;
      jtdr_pkg::SHF_IR: n = tms ? jtdr_pkg::EX1_IR : jtdr_pkg::SHF_IR;
      jtdr_pkg::EX1_IR: n = tms ? jtdr_pkg::UPD_IR : jtdr_pkg::PAU_IR;
      jtdr_pkg::PAU_IR: n = tms ? jtdr_pkg::EX2_IR : jtdr_pkg::PAU_IR;
      jtdr_pkg::EX2_IR: n = tms ? jtdr_pkg::UPD_IR : jtdr_pkg::SHF_IR;
      jtdr_pkg::UPD_IR: n = tms ? jtdr_pkg::SEL_DR : jtdr_pkg::RTI;
      default: n = jtdr_pkg::TLR;
    endcase
    return n;
  endfunction

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  // Edges seen on the second sync stage only
  assign rise = r.pin_s.tck & ~r.tck_d;
  assign fall = ~r.pin_s.tck & r.tck_d;
  assign is_extest = (r.ir == jtdr_pkg::IR_EXTEST);
  assign is_sampz = (r.ir == jtdr_pkg::IR_SAMPZ);
  assign sel_id = (r.ir == jtdr_pkg::IR_IDCODE);
  assign sel_bsr = is_extest | is_sampz | (r.ir == jtdr_pkg::IR_SAMPLE);
  // Reserved codes fall back to the shortest path
  assign sel_byp = ~sel_id & ~sel_bsr;

  // ------------------------------------------------------------
  // Next value
  // ------------------------------------------------------------
  always_comb begin
    r_nxt = r;
    r_nxt.pin_m = pin_i;
    r_nxt.pin_s = r.pin_m;
    r_nxt.tck_d = r.pin_s.tck;
    r_nxt.pad_m = pad_level_i;
    r_nxt.pad_s = r.pad_m;
    if (rise) begin
      case (r.tap)
        jtdr_pkg::CAP_DR: begin
          if (sel_byp) begin
            r_nxt.byp = jtdr_pkg::BYP_CAP;
          end else if (sel_id) begin
            r_nxt.id_sh = ID_WORD;
          end else begin
            r_nxt.bsr = {jtdr_pkg::INT_CELL_CAP, r.pad_s & ~NC_MASK};
          end
        end
        jtdr_pkg::SHF_DR: begin
          if (sel_byp) begin
            r_nxt.byp = r.pin_s.tdi;
          end else if (sel_id) begin
            r_nxt.id_sh = {r.pin_s.tdi, r.id_sh[31:1]};
          end else begin
            r_nxt.bsr = {r.pin_s.tdi, r.bsr[126:1]};
          end
        end
        jtdr_pkg::CAP_IR: r_nxt.ir_sh = jtdr_pkg::IR_RST;
        jtdr_pkg::SHF_IR: r_nxt.ir_sh = {r.pin_s.tdi, r.ir_sh[2:1]};
        default: r_nxt.ir_sh = r.ir_sh;
      endcase
      r_nxt.tap = tap_next(r.tap, r.pin_s.tms);
    end
    if (fall) begin
      case (r.tap)
        jtdr_pkg::UPD_IR: r_nxt.ir = r.ir_sh;
        // Pad drive values move only here, never during shifting
        jtdr_pkg::UPD_DR: begin
          if (sel_bsr) begin
            r_nxt.upd = r.bsr;
          end
        end
        jtdr_pkg::TLR: r_nxt.ir = jtdr_pkg::IR_RST;
        default: r_nxt.ir = r.ir;
      endcase
      r_nxt.tdo_oe = (r.tap == jtdr_pkg::SHF_DR) |
                     (r.tap == jtdr_pkg::SHF_IR);
      if (r.tap == jtdr_pkg::SHF_IR) begin
        r_nxt.tdo = r.ir_sh[0];
      end else if (sel_byp) begin
        r_nxt.tdo = r.byp;
      end else if (sel_id) begin
        r_nxt.tdo = r.id_sh[0];
      end else begin
        r_nxt.tdo = r.bsr[0];
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (srst_i) begin
      r <= '0;
      r.tap <= jtdr_pkg::TLR;
      r.ir <= jtdr_pkg::IR_RST;
      r.ir_sh <= jtdr_pkg::IR_RST;
      r.bsr <= jtdr_pkg::BSR_RST;
      r.upd <= jtdr_pkg::BSR_RST;
    end else begin
      r <= r_nxt;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign tdo_o = r.tdo;
  assign tdo_oe_o = r.tdo_oe;
  assign pad_drive_o = r.upd[125:0];
  assign ctl_o.pad_sel = is_extest;
  // Cell 127 gates data drivers; high-Z sample floats them
  assign ctl_o.dq_hiz = is_sampz |
    (is_extest & ~r.upd[jtdr_pkg::INT_CELL_POS]);
  assign ctl_o.odt_off = is_extest | is_sampz;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (srst_i);

  byp_capture_a: assert property (
    rise && r.tap == jtdr_pkg::CAP_DR && sel_byp |=> r.byp == 1'b0)
    else $error("bypass stage did not capture zero");

  id_capture_a: assert property (
    rise && r.tap == jtdr_pkg::CAP_DR && sel_id |=> r.id_sh == ID_WORD)
    else $error("identification word not captured");

  id_start_a: assert property (
    rise && r.tap == jtdr_pkg::CAP_DR && sel_id |=> r.id_sh[0] == 1'b1)
    else $error("start bit not one");

  id_shift_a: assert property (
    rise && r.tap == jtdr_pkg::SHF_DR && sel_id |=>
    r.id_sh == {$past(r.pin_s.tdi), $past(r.id_sh[31:1])})
    else $error("identification shift direction wrong");

  bsr_capture_a: assert property (
    rise && r.tap == jtdr_pkg::CAP_DR && sel_bsr |=>
    r.bsr[126] && (r.bsr[125:0] & NC_MASK) == '0)
    else $error("scan chain capture values wrong");

  bsr_shift_a: assert property (
    rise && r.tap == jtdr_pkg::SHF_DR && sel_bsr |=>
    r.bsr[126] == $past(r.pin_s.tdi))
    else $error("chain input not at position 127");

  pin_hold_a: assert property (
    r.tap != jtdr_pkg::UPD_DR |=> $stable(r.upd))
    else $error("pin values moved outside update");

  drv_gate_a: assert property (
    is_extest |-> ctl_o.dq_hiz == ~r.upd[126])
    else $error("driver gate not following cell 127");

  odt_off_a: assert property (
    is_extest || is_sampz |-> ctl_o.odt_off)
    else $error("termination left on");

  sampz_hiz_a: assert property (
    is_sampz |-> ctl_o.dq_hiz && !ctl_o.pad_sel)
    else $error("high-Z sample left drivers on");

  tlr_ir_a: assert property (
    fall && r.tap == jtdr_pkg::TLR |=> r.ir == jtdr_pkg::IR_IDCODE)
    else $error("reset state did not load identification code");

  tdo_fall_a: assert property (
    !fall |=> $stable(r.tdo))
    else $error("serial output moved off falling edge");

  byp_shift_a: assert property (
    rise && r.tap == jtdr_pkg::SHF_DR && sel_byp |=>
    r.byp == $past(r.pin_s.tdi))
    else $error("bypass stage did not take serial input");

  upd_load_a: assert property (
    fall && r.tap == jtdr_pkg::UPD_DR && sel_bsr |=>
    r.upd == $past(r.bsr))
    else $error("update cells not loaded from chain");

  ir_capture_a: assert property (
    rise && r.tap == jtdr_pkg::CAP_IR |=> r.ir_sh == jtdr_pkg::IR_IDCODE)
    else $error("capture did not preset instruction stage");

  ir_update_a: assert property (
    fall && r.tap == jtdr_pkg::UPD_IR |=>
    r.ir == $past(r.ir_sh))
    else $error("instruction not taken at update");

  pad_sel_a: assert property (
    ctl_o.pad_sel |-> r.ir == jtdr_pkg::IR_EXTEST)
    else $error("pins taken over outside external test");

  oe_shift_a: assert property (
    fall && r.tap == jtdr_pkg::SHF_DR |=> tdo_oe_o)
    else $error("serial output not enabled while shifting");

  id_first_a: assert property (
    fall && r.tap == jtdr_pkg::SHF_DR && sel_id |=>
    tdo_o == $past(r.id_sh[0]))
    else $error("identification word not sent from bit 0");

  bsr_first_a: assert property (
    fall && r.tap == jtdr_pkg::SHF_DR && sel_bsr |=>
    tdo_o == $past(r.bsr[0]))
    else $error("chain not sent from position 1");

  cov_extest_upd: cover property (
    fall && r.tap == jtdr_pkg::UPD_DR && is_extest);
  cov_id_shift: cover property (
    rise && r.tap == jtdr_pkg::SHF_DR && sel_id);
  cov_byp_shift: cover property (
    rise && r.tap == jtdr_pkg::SHF_DR && sel_byp);
  cov_sampz_capture: cover property (
    rise && r.tap == jtdr_pkg::CAP_DR && is_sampz);
  cov_reserved_byp: cover property (
    rise && r.tap == jtdr_pkg::CAP_DR && sel_byp &&
    r.ir != jtdr_pkg::IR_BYPASS);

endmodule

// ### jtdr_tap_host.sv
// Test controller model that drives the test pins of the data registers.
// Assumes ref_clk_i is the block's clock; one test clock is 8 of its cycles.
`timescale 1ns/1ps
module jtdr_tap_host (
  input wire logic ref_clk_i,
  input wire logic tdo_i,
  output jtdr_pkg::jtdr_pin_t pin_o
);
  // ----------------------------------------
  // Pin sequencing
  // ----------------------------------------
  initial pin_o = '0;
  // Test clock stands still between calls
  task automatic tick(input logic tms, input logic tdi, output logic tdo);
    @(posedge ref_clk_i);
    pin_o.tms <= tms;
    pin_o.tdi <= tdi;
    repeat (3) @(posedge ref_clk_i);
    pin_o.tck <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    tdo = tdo_i; // Late sample, still stable from last fall
    pin_o.tck <= 1'b0;
  endtask
  // Idle ticks toggle TDI so that a stale level is never trusted
  task automatic idle(input logic tms); // Step, then settle idle
    logic d;
    tick(tms, ~pin_o.tdi, d);
    tick(1'b0, ~pin_o.tdi, d);
  endtask
  task automatic tlr(); // Five TMS highs reach reset
    logic d;
    repeat (4) tick(1'b1, ~pin_o.tdi, d);
    idle(1'b1);
  endtask
  // IR or DR scan from idle, LSB first; hold stops in Pause-DR
  task automatic scan(input bit ir, input int n, input logic [127:0] din,
    output logic [127:0] dout, input bit hold = 1'b0);
    logic d;
    dout = '0;
    tick(1'b1, ~pin_o.tdi, d);
    if (ir) tick(1'b1, ~pin_o.tdi, d);
    repeat (2) tick(1'b0, ~pin_o.tdi, d);
    for (int i = 0; i < n; i++) tick(i == n - 1, din[i], dout[i]);
    if (hold) tick(1'b0, ~pin_o.tdi, d);
    else idle(1'b1);
  endtask
  task automatic resume(); // Exit2, Update-DR, idle
    logic d;
    tick(1'b1, ~pin_o.tdi, d);
    idle(1'b1);
  endtask
endmodule

// ### jtdr_data_regs_tb.sv
// Self-checking bench for the test-port data registers.
// Assumes the host model drives the test pins; pad levels come from here.
`timescale 1ns/1ps
module jtdr_data_regs_tb;
  // ----------------------------------------
  // Setup
  // ----------------------------------------
  localparam logic [19:0] PART = 20'h3C96A; // Arbitrary value
  localparam logic [10:0] MAKER = 11'h155; // Arbitrary value
  // Mask overlaps set pad bits, so a lost mask shows
  localparam logic [125:0] NC = 126'hF << 48;
  localparam logic [125:0] PADS = 126'h2AAA_5F0F_C3C3_9E01_FFFF_0123_4567_89AB;
  localparam logic [125:0] NPADS = ~PADS;
  logic ref_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [125:0] pad_level_i = '0;
  jtdr_pkg::jtdr_pin_t pin;
  logic tdo_o;
  logic tdo_oe_o;
  logic [125:0] pad_drive_o;
  jtdr_pkg::jtdr_ctl_t ctl_o;
  logic [127:0] q;
  int fails = 0;
  int comparisons = 0;
  int oe_cycles = 0;

  always #50 ref_clk_i = ~ref_clk_i;
  always @(posedge ref_clk_i) begin
    if (tdo_oe_o) oe_cycles <= oe_cycles + 1;
  end

  jtdr_data_regs #(.PART_ID(PART), .MAKER_ID(MAKER), .NC_MASK(NC)) dut (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .pin_i(pin),
    .pad_level_i(pad_level_i), .tdo_o(tdo_o), .tdo_oe_o(tdo_oe_o),
    .pad_drive_o(pad_drive_o), .ctl_o(ctl_o));
  jtdr_tap_host host (.ref_clk_i(ref_clk_i), .tdo_i(tdo_o), .pin_o(pin));

  // ----------------------------------------
  // Helpers and scenarios
  // ----------------------------------------
  task automatic chk(input logic [127:0] got, input logic [127:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic ir(input logic [2:0] code);
    host.scan(1'b1, 3, {125'h0, code}, q);
    chk(q[2:0], 3'h1); // Capture-IR loads identification
  endtask
  task automatic t_reset();
    chk(pad_drive_o, '0); // Update cells clear
    chk({tdo_oe_o, ctl_o}, 4'h0); // Idle controls
    host.tlr();
    ir(jtdr_pkg::IR_IDCODE);
    $display("test reset done");
  endtask
  task automatic t_idcode();
    int oe0;
    oe0 = oe_cycles;
    host.scan(1'b0, 64, {96'h0, 32'hC0DE_1234}, q);
    chk(128'(oe_cycles - oe0), 128'h200); // 64 shifts of 8 clocks
    chk(q[31:0], {PART, MAKER, 1'b1}); // Word layout
    chk(q[63:32], 32'hC0DE_1234); // TDI enters bit 31
    $display("test idcode done");
  endtask
  task automatic t_bypass();
    logic [2:0] codes [4] = '{3'h7, 3'h3, 3'h5, 3'h6};
    foreach (codes[i]) begin
      ir(codes[i]);
      host.scan(1'b0, 8, 128'hB5, q);
      chk(q, 128'h6A); // Zero first, one stage
    end
    $display("test bypass done");
  endtask
  task automatic t_capture();
    logic [2:0] codes [3] = '{jtdr_pkg::IR_SAMPLE, jtdr_pkg::IR_SAMPZ,
      jtdr_pkg::IR_EXTEST};
    logic [2:0] ctl [3] = '{3'h0, 3'h3, 3'h5};
    pad_level_i <= PADS;
    foreach (codes[i]) begin
      ir(codes[i]);
      chk(ctl_o, ctl[i]); // Pins, drivers, termination
      host.scan(1'b0, 127, {2'h1, NPADS}, q);
      chk(q, {2'h1, PADS & ~NC}); // Capture
    end
    $display("test capture done");
  endtask
  task automatic t_extest();
    host.scan(1'b0, 127, {2'h0, PADS}, q, 1'b1);
    chk(pad_drive_o, NPADS); // Shifting leaves the pins alone
    host.resume();
    chk(pad_drive_o, PADS); // Update moves cells to pins
    chk(ctl_o, 3'h7); // Cell 127 at zero floats drivers
    host.tlr();
    chk(ctl_o, 3'h0); // TMS reset restores identification
    $display("test extest done");
  endtask
  task automatic test_done();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ----------------------------------------
  // Sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk_i);
    srst_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    t_reset();
    t_idcode();
    t_bypass();
    t_capture();
    t_extest();
    test_done();
  end
  // About 740 test clocks expected; five times that is a hang
  initial begin
    #3_000_000;
    fails++;
    $display("unexpected at %0t: watchdog expired", $time);
    test_done();
  end
endmodule
